// ==== verilog/dpcfg_pkg.sv ====
// Purpose: shared constants for the datapath configuration register block
// Assumes: 8-bit register port, single clock domain
// Notes: field positions and reset value of the configuration register
package dpcfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] CFG_OFFSET = 8'h22;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam int LOCK_BIT = 7;
    localparam int PASS_BIT = 6;
    localparam int POL_BIT = 5;
    localparam int INHIBIT_BIT = 4;
    localparam int QUAD_SRC_BIT = 3;
    localparam int NARROW_BIT = 2;
    localparam int ISLAND_BIT = 1;
    localparam int QUAD_EN_BIT = 0;
    localparam int FC_W = 7;
    localparam int PIX_W = 24;
    localparam int CHAN_W = 8;
    localparam int NARROW_DROP = 2;
endpackage : dpcfg_pkg

// ==== verilog/dpcfg_cfg_if.sv ====
// Purpose: carries the decoded configuration bits to the pixel path
// Assumes: all signals on i_clk
// Notes: driven by the register bank, read by the pixel path
`timescale 1ns/1ps
interface dpcfg_cfg_if;
    logic pass_through;
    logic strobe_polarity;
    logic audio_inhibit;
    logic narrow_colour;
    modport bank (output pass_through, output strobe_polarity, output audio_inhibit, output narrow_colour);
    modport path (input pass_through, input strobe_polarity, input audio_inhibit, input narrow_colour);
endinterface : dpcfg_cfg_if

// ==== verilog/dpcfg_pixpath.sv ====
// Purpose: pixel output stage steered by the configuration bits
// Assumes: pixel, strobe and audio inputs come from logic on i_clk
// Notes: one cycle from inputs to outputs
`timescale 1ns/1ps
module dpcfg_pixpath #(
    parameter int PIX_W = dpcfg_pkg::PIX_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    dpcfg_cfg_if.path cfg,
    input wire logic [PIX_W-1:0] i_pix_data,
    input wire logic i_pix_strobe,
    input wire logic [PIX_W-1:0] i_aud_data,
    input wire logic i_aud_valid,
    output logic [PIX_W-1:0] o_pix_data,
    output logic o_pix_valid,
    output logic o_pix_aux
);
    logic strobe_active;
    logic pass_now;
    logic aud_ok;
    logic [PIX_W-1:0] pix_masked;
    logic [PIX_W-1:0] pix_data_next;

    // strobe sense and forwarding decision
    assign strobe_active = cfg.strobe_polarity ? ~i_pix_strobe : i_pix_strobe;
    assign pass_now = strobe_active | cfg.pass_through;
    assign aud_ok = i_aud_valid & ~strobe_active & ~cfg.audio_inhibit & ~cfg.pass_through;

    // narrow colour drops the low bits of each channel
    always_comb
    begin
        pix_masked = i_pix_data;
        if (cfg.narrow_colour)
        begin
            for (int c = 0; c < PIX_W / dpcfg_pkg::CHAN_W; c++)
            begin
                pix_masked[c*dpcfg_pkg::CHAN_W +: dpcfg_pkg::NARROW_DROP] = '0;
            end
        end
        if (pass_now)
            pix_data_next = pix_masked;
        else if (aud_ok)
            pix_data_next = i_aud_data;
        else
            pix_data_next = '0;
    end

    // registered pixel outputs
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pix_data <= '0;
            o_pix_valid <= 1'b0;
            o_pix_aux <= 1'b0;
        end
        else
        begin
            o_pix_data <= pix_data_next;
            o_pix_valid <= pass_now;
            o_pix_aux <= ~pass_now & aud_ok;
        end
    end

    pass_forwards_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        cfg.pass_through |=> o_pix_valid)
        else $error("pass-through did not forward pixels");
    polarity_low_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (cfg.strobe_polarity && !i_pix_strobe) |=> o_pix_valid)
        else $error("active-low strobe not honoured");
    polarity_high_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!cfg.strobe_polarity && !i_pix_strobe && !cfg.pass_through) |=> !o_pix_valid)
        else $error("idle strobe forwarded pixels");
    audio_inhibit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (cfg.audio_inhibit || cfg.pass_through) |=> !o_pix_aux)
        else $error("audio driven on pixel pins while blocked");
    audio_out_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (aud_ok && !strobe_active) |=> (o_pix_aux && o_pix_data == $past(i_aud_data)))
        else $error("audio not placed on pixel pins");
    narrow_mask_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (cfg.narrow_colour && pass_now)
        |=> (o_pix_data[1:0] == 2'h0 && o_pix_data[9:8] == 2'h0 && o_pix_data[17:16] == 2'h0))
        else $error("narrow colour left low bits set");
endmodule : dpcfg_pixpath

// ==== verilog/dpcfg_top.sv ====
// Purpose: datapath configuration register with forward-channel loading
// Assumes: register port and forward-channel loads on i_clk
// Notes: read data stand one cycle after the read strobe
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - bits six to zero follow remote serializer while bit seven is clear
// - pass-through forwards pixels regardless of strobe
// - polarity bit selects strobe active sense
// - inhibit bit keeps audio off pixel pins
// - source bit: bit zero or forced off
// - narrow bit selects 18 or 24 bit
// - carriage bit: in-band or data-island audio
// - quad enable bit turns four channels on
// - register at 22h, resets to zero
module dpcfg_top #(
    parameter int PIX_W = dpcfg_pkg::PIX_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [dpcfg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dpcfg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [dpcfg_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_fc_load,
    input wire logic [dpcfg_pkg::FC_W-1:0] i_fc_data,
    input wire logic [PIX_W-1:0] i_pix_data,
    input wire logic i_pix_strobe,
    input wire logic [PIX_W-1:0] i_aud_data,
    input wire logic i_aud_valid,
    output logic [PIX_W-1:0] o_pix_data,
    output logic o_pix_valid,
    output logic o_pix_aux,
    output logic o_protect_en,
    output logic o_pkt_audio_block,
    output logic o_audio_island,
    output logic o_quad_audio_en,
    output logic o_narrow_colour
);
    logic [dpcfg_pkg::DATA_W-1:0] cfg_reg;
    logic [dpcfg_pkg::DATA_W-1:0] cfg_next;
    logic [dpcfg_pkg::DATA_W-1:0] rdata_next;
    logic wr_hit;
    logic fc_take;
    logic quad_next;

    dpcfg_cfg_if cfg_bus ();

    // address decode
    // a write to any other address falls away unseen
    assign wr_hit = i_wr && (i_addr == dpcfg_pkg::CFG_OFFSET);
    assign fc_take = i_fc_load && !cfg_reg[dpcfg_pkg::LOCK_BIT];

    // next register value: a local write beats a same-cycle remote load
    always_comb
    begin
        cfg_next = cfg_reg;
        if (wr_hit)
            cfg_next = i_wdata;
        else if (fc_take)
            cfg_next = {cfg_reg[dpcfg_pkg::LOCK_BIT], i_fc_data};
    end

    // configuration register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cfg_reg <= dpcfg_pkg::CFG_RESET;
        else
            cfg_reg <= cfg_next;
    end

    // read data, one cycle after the strobe
    always_comb
    begin
        if (i_rd && i_addr == dpcfg_pkg::CFG_OFFSET)
            rdata_next = cfg_reg;
        else
            rdata_next = dpcfg_pkg::RDATA_UNMAPPED;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= dpcfg_pkg::RDATA_UNMAPPED;
        else
            o_rdata <= rdata_next;
    end

    // quad audio enable source select
    assign quad_next = cfg_next[dpcfg_pkg::QUAD_SRC_BIT] & cfg_next[dpcfg_pkg::QUAD_EN_BIT];

    // mode outputs are built from cfg_next so they change with cfg_reg;
    // pass-through trades content protection and packet audio for framing freedom
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_protect_en <= 1'b1;
            o_pkt_audio_block <= 1'b0;
        end
        else
        begin
            o_protect_en <= ~cfg_next[dpcfg_pkg::PASS_BIT];
            o_pkt_audio_block <= cfg_next[dpcfg_pkg::PASS_BIT];
        end
    end

    // carriage select: bit one set means in-band, clear means data islands
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_audio_island <= 1'b1;
        else
            o_audio_island <= ~cfg_next[dpcfg_pkg::ISLAND_BIT];
    end

    // four-channel audio enable after the source select
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_quad_audio_en <= 1'b0;
        else
            o_quad_audio_en <= quad_next;
    end

    // colour depth select, high for 18-bit
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_narrow_colour <= 1'b0;
        else
            o_narrow_colour <= cfg_next[dpcfg_pkg::NARROW_BIT];
    end

    // configuration bits towards the pixel path
    assign cfg_bus.pass_through = cfg_reg[dpcfg_pkg::PASS_BIT];
    assign cfg_bus.strobe_polarity = cfg_reg[dpcfg_pkg::POL_BIT];
    assign cfg_bus.audio_inhibit = cfg_reg[dpcfg_pkg::INHIBIT_BIT];
    assign cfg_bus.narrow_colour = cfg_reg[dpcfg_pkg::NARROW_BIT];

    dpcfg_pixpath #(
        .PIX_W(PIX_W)
    ) u_pixpath (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .cfg(cfg_bus.path),
        .i_pix_data(i_pix_data),
        .i_pix_strobe(i_pix_strobe),
        .i_aud_data(i_aud_data),
        .i_aud_valid(i_aud_valid),
        .o_pix_data(o_pix_data),
        .o_pix_valid(o_pix_valid),
        .o_pix_aux(o_pix_aux)
    );

    // register bank checks
    lock_holds_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (cfg_reg[dpcfg_pkg::LOCK_BIT] && !wr_hit) |=> $stable(cfg_reg))
        else $error("locked register changed without a local write");
    fc_load_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_fc_load && !cfg_reg[dpcfg_pkg::LOCK_BIT] && !wr_hit)
        |=> cfg_reg[6:0] == $past(i_fc_data))
        else $error("remote load not taken");
    write_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wr_hit ##1 (i_rd && i_addr == dpcfg_pkg::CFG_OFFSET && !i_fc_load && !i_wr))
        |=> o_rdata == $past(i_wdata, 2))
        else $error("read back differs from write");
    unmapped_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_rd && i_addr != dpcfg_pkg::CFG_OFFSET) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    quad_forced_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !cfg_reg[dpcfg_pkg::QUAD_SRC_BIT] |-> !o_quad_audio_en)
        else $error("quad audio enabled while forced off");
    quad_follow_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        cfg_reg[dpcfg_pkg::QUAD_SRC_BIT] |-> o_quad_audio_en == cfg_reg[dpcfg_pkg::QUAD_EN_BIT])
        else $error("quad audio enable does not follow bit zero");
    protect_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_protect_en == !cfg_reg[dpcfg_pkg::PASS_BIT] && o_pkt_audio_block == cfg_reg[dpcfg_pkg::PASS_BIT])
        else $error("protection or audio block wrong under pass-through");
    island_sel_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_audio_island == !cfg_reg[dpcfg_pkg::ISLAND_BIT])
        else $error("audio carriage select not applied");

    // write and remote load checks
    write_lands_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        wr_hit |=> cfg_reg == $past(i_wdata))
        else $error("local write not stored");
    write_wins_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (wr_hit && i_fc_load) |=> cfg_reg == $past(i_wdata))
        else $error("remote load beat a local write");
    no_change_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!wr_hit && !fc_take) |=> $stable(cfg_reg))
        else $error("register changed with no write or load");
    lock_kept_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !wr_hit |=> $stable(cfg_reg[dpcfg_pkg::LOCK_BIT]))
        else $error("lock bit changed without a local write");
    stray_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_wr && i_addr != dpcfg_pkg::CFG_OFFSET && !fc_take) |=> $stable(cfg_reg))
        else $error("write to another address reached the register");

    // read port checks
    read_value_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_rd && i_addr == dpcfg_pkg::CFG_OFFSET) |=> o_rdata == $past(cfg_reg))
        else $error("read data differ from register");
    rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_rd |=> o_rdata == dpcfg_pkg::RDATA_UNMAPPED)
        else $error("read data present without a read");

    // mode output checks
    narrow_sel_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_narrow_colour == cfg_reg[dpcfg_pkg::NARROW_BIT])
        else $error("colour depth select not applied");
    quad_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !cfg_reg[dpcfg_pkg::QUAD_EN_BIT] |-> !o_quad_audio_en)
        else $error("quad audio enabled while bit zero clear");
    protect_idle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !cfg_reg[dpcfg_pkg::PASS_BIT] |-> (o_protect_en && !o_pkt_audio_block))
        else $error("protection off without pass-through");
endmodule : dpcfg_top

// ==== testbench/dpcfg_fc_model.sv ====
// Purpose: remote serializer model that loads bits six to zero over the forward channel
// Assumes: loads are launched just after a rising edge of i_clk
// Notes: idle data lines show the inverse of the last value, never a stale copy
`timescale 1ns/1ps
module dpcfg_fc_model (
    input wire logic i_clk,
    output logic o_fc_load,
    output logic [dpcfg_pkg::FC_W-1:0] o_fc_data
);
    // idle state at time zero
    initial
    begin
        o_fc_load = 1'b0;
        o_fc_data = 7'h00;
    end
    // one-cycle load pulse, bit seven is never carried by the remote end
    task automatic send(input logic [dpcfg_pkg::FC_W-1:0] d);
        @(posedge i_clk);
        o_fc_load <= 1'b1;
        o_fc_data <= d;
        @(posedge i_clk);
        o_fc_load <= 1'b0;
        o_fc_data <= ~d; // released lines do not hold the old value
    endtask : send
endmodule : dpcfg_fc_model

// ==== testbench/datapath_config_register_tb_top.sv ====
// Purpose: self-checking bench for the datapath configuration register
// Assumes: 125 MHz clock, active-low asynchronous reset held for 10 cycles
// Notes: register port driven by plain tasks, forward channel by the partner model
`timescale 1ns/1ps
module datapath_config_register_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic fc_load;
    logic [6:0] fc_data;
    logic [23:0] pix = 24'h000000;
    logic stb = 1'b0;
    logic aval = 1'b0;
    logic [23:0] aud = 24'h000000;
    logic [23:0] pdata;
    logic pvalid, paux, prot, pblk, isl, quad, narrow;
    int num_errors = 0;
    int checked = 0;
    logic [7:0] d;
    // clock generator, 8 ns period
    always #4 clk = ~clk;
    dpcfg_fc_model u_fc (.i_clk(clk), .o_fc_load(fc_load), .o_fc_data(fc_data));
    dpcfg_top u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_fc_load(fc_load), .i_fc_data(fc_data), .i_pix_data(pix), .i_pix_strobe(stb),
        .i_aud_data(aud), .i_aud_valid(aval), .o_pix_data(pdata), .o_pix_valid(pvalid),
        .o_pix_aux(paux), .o_protect_en(prot), .o_pkt_audio_block(pblk), .o_audio_island(isl),
        .o_quad_audio_en(quad), .o_narrow_colour(narrow));
    task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
        checked++;
        if (got !== ex)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic cfg_chk(input logic [6:0] f);
        chk("protect", {23'h0, ~f[6]}, {23'h0, prot});
        chk("pkt_block", {23'h0, f[6]}, {23'h0, pblk});
        chk("island", {23'h0, ~f[1]}, {23'h0, isl});
        chk("quad", {23'h0, f[3] & f[0]}, {23'h0, quad});
        chk("narrow", {23'h0, f[2]}, {23'h0, narrow});
    endtask : cfg_chk
    task automatic t_reset_unmapped();
        rd_reg(8'h22, d);
        chk("reset_value", 24'h0, {16'h0, d});
        cfg_chk(7'h00);
        wr_reg(8'h23, 8'hff);
        rd_reg(8'h23, d);
        chk("unmapped_read", 24'h0, {16'h0, d});
        rd_reg(8'h22, d);
        chk("after_unmapped", 24'h0, {16'h0, d});
        $display("reset and unmapped test done");
    endtask : t_reset_unmapped
    task automatic t_remote();
        logic [6:0] vals [5] = '{7'h7f, 7'h07, 7'h0f, 7'h4a, 7'h00};
        foreach (vals[i])
        begin
            u_fc.send(vals[i]);
            rd_reg(8'h22, d);
            chk("remote_load", {17'h0, vals[i]}, {16'h0, d});
            cfg_chk(vals[i]);
        end
        $display("remote load test done");
    endtask : t_remote
    task automatic t_lock();
        wr_reg(8'h22, 8'h95);
        u_fc.send(7'h6a);
        rd_reg(8'h22, d);
        chk("locked", 24'h95, {16'h0, d});
        cfg_chk(7'h15);
        wr_reg(8'h22, 8'h00);
        u_fc.send(7'h6a);
        rd_reg(8'h22, d);
        chk("unlocked", 24'h6a, {16'h0, d});
        $display("lock test done");
    endtask : t_lock
    // write then read with no gap, then a write racing a remote load
    task automatic t_b2b();
        @(posedge clk);
        wr <= 1'b1;
        addr <= 8'h22;
        wdata <= 8'h5c;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("b2b_read", 24'h5c, {16'h0, rdata});
        cfg_chk(7'h5c);
        @(posedge clk);
        #1 chk("rdata_idle", 24'h0, {16'h0, rdata});
        fork
            wr_reg(8'h22, 8'h11);
            u_fc.send(7'h33);
        join
        rd_reg(8'h22, d);
        chk("write_wins", 24'h11, {16'h0, d});
        $display("back to back test done");
    endtask : t_b2b
    // reset in mid-run clears the register and returns the pixel and mode outputs to their reset values
    task automatic t_midreset();
        wr_reg(8'h22, 8'hff);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        #1 chk("reset_pix_valid", 24'h0, {23'h0, pvalid});
        chk("reset_pix_data", 24'h0, pdata);
        cfg_chk(7'h00);
        @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(8'h22, d);
        chk("reset_again", 24'h0, {16'h0, d});
        $display("mid-run reset test done");
    endtask : t_midreset
    // program the register, let it reach the pixel path, then send one beat
    task automatic px(input logic [7:0] c, input logic s, input logic ev, input logic ea, input logic [23:0] ed);
        wr_reg(8'h22, c);
        @(posedge clk);
        pix <= 24'hffffff;
        stb <= s;
        aval <= 1'b1;
        aud <= {3{c ^ 8'h5a}};
        @(posedge clk);
        #1 chk("pix_valid", {23'h0, ev}, {23'h0, pvalid});
        chk("pix_aux", {23'h0, ea}, {23'h0, paux});
        chk("pix_data", ed, pdata);
    endtask : px
    task automatic t_pixel();
        px(8'h00, 1'b1, 1'b1, 1'b0, 24'hffffff);
        px(8'h00, 1'b0, 1'b0, 1'b1, 24'h5a5a5a);
        px(8'h20, 1'b0, 1'b1, 1'b0, 24'hffffff);
        px(8'h20, 1'b1, 1'b0, 1'b1, 24'h7a7a7a);
        px(8'h10, 1'b0, 1'b0, 1'b0, 24'h000000);
        px(8'h40, 1'b0, 1'b1, 1'b0, 24'hffffff);
        px(8'h04, 1'b1, 1'b1, 1'b0, 24'hfcfcfc);
        $display("pixel path test done");
    endtask : t_pixel
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_unmapped();
        t_remote();
        t_lock();
        t_b2b();
        t_midreset();
        t_pixel();
        close_out();
    end
    // hang guard
    initial
    begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule : datapath_config_register_tb_top
